// File: src/idm_dma_command.v
// Command and status register logic of a two-channel bus-master IDE DMA engine.
// Assumes single-cycle I/O strobes on clk_sys, a base address held by the PCI
// configuration logic, and engine event pulses synchronous to clk_sys.
//
// What this block does
// - A 16-byte I/O window is decoded at the base given by the base address register.
// - Every register in the window accepts byte, word and dword accesses via byte enables.
// - Primary command sits at offset 00h and secondary at 08h, both resetting to zero.
// - Command bit 3 picks the direction, 0 for reads and 1 for writes.
// - Writing 1 to command bit 0 starts bus-master operation of that channel.
// - Data moves between drive and memory only while the run bit is 1.
// - Writing 0 to the run bit stops the engine, discards its state, and a new 1 starts afresh.
// - Clearing run while active and before the drive signals completion aborts the command.
// - The active flag sets on start and clears on last region, run clear or error.
// - The interrupt flag sets on a rising drive interrupt edge and clears by writing 1.
// - The error flag sets on a target or master abort and clears by writing 1.
`timescale 1ns/1ps
`include "idm_dma_command_defines.vh"

module idm_dma_command (
  input wire clk_sys,
  input wire arst_n,
  input wire clk_en,
  input wire io_space_en,
  input wire [`IDM_BASE_W-1:0] dma_io_base,
  input wire io_wr,
  input wire io_rd,
  input wire [31:0] io_addr,
  input wire [3:0] io_be,
  input wire [31:0] io_wdata,
  output reg [31:0] io_rdata,
  output reg io_ack,
  output wire io_hit,
  input wire [1:0] last_region_done,
  input wire [1:0] pci_abort,
  input wire [1:0] drive_irq,
  output wire [1:0] bus_master_run,
  output wire [1:0] transfer_direction,
  output wire [1:0] xfer_enable,
  output wire [1:0] start_pulse,
  output wire [1:0] abort_pulse,
  output wire [7:0] pri_ide_dma_status,
  output wire [7:0] sec_ide_dma_status
);

  // Window decode on the upper address bits against the programmed base
  function idm_hit;
    input [31:0] addr;
    input [`IDM_BASE_W-1:0] base;
    input en;
    begin
      idm_hit = en && (addr[31:`IDM_WIN_BITS] == base);
    end
  endfunction

  // Byte-lane write strobe for one channel's dword that holds command and status
  function idm_lane_wr;
    input [31:0] addr;
    input [3:0] be;
    input ch;
    input integer lane;
    begin
      idm_lane_wr = (addr[`IDM_CH_SEL_BIT] == ch) && !addr[`IDM_DW_SEL_BIT] && be[lane];
    end
  endfunction

  // Command byte as read back; reserved positions are tied low
  function [7:0] idm_cmd_byte;
    input dir;
    input run;
    begin
      idm_cmd_byte = 8'h00;
      idm_cmd_byte[`IDM_CMD_DIR_BIT] = dir;
      idm_cmd_byte[`IDM_CMD_RUN_BIT] = run;
    end
  endfunction

  // Status byte as read back; bits 7 and 4:3 are tied low
  function [7:0] idm_sts_byte;
    input [1:0] cap;
    input irq;
    input err;
    input act;
    begin
      idm_sts_byte = 8'h00;
      idm_sts_byte[`IDM_STS_CAP1_BIT] = cap[1];
      idm_sts_byte[`IDM_STS_CAP0_BIT] = cap[0];
      idm_sts_byte[`IDM_STS_IRQ_BIT] = irq;
      idm_sts_byte[`IDM_STS_ERR_BIT] = err;
      idm_sts_byte[`IDM_STS_ACT_BIT] = act;
    end
  endfunction

  // Reset images of both bytes, so each stored bit resets from its own field
  localparam [7:0] CMD_RST = `IDM_CMD_RESET;
  localparam [7:0] STS_RST = `IDM_STS_RESET;

  wire acc_wr;
  wire [7:0] cmd_wbyte;
  wire [7:0] sts_wbyte;
  wire [7:0] pri_cmd;
  wire [7:0] sec_cmd;

  assign io_hit = idm_hit(io_addr, dma_io_base, io_space_en) && (io_wr || io_rd);
  assign acc_wr = io_hit && io_wr && clk_en;
  assign cmd_wbyte = io_wdata[8*`IDM_CMD_LANE +: 8];
  assign sts_wbyte = io_wdata[8*`IDM_STS_LANE +: 8];

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : chan
      reg run_reg;
      reg dir_reg;
      reg act_reg;
      reg err_reg;
      reg irq_reg;
      reg [1:0] cap_reg;
      reg irq_prev_reg;
      reg run_next;
      reg dir_next;
      reg act_next;
      reg err_next;
      reg irq_next;
      reg [1:0] cap_next;
      wire cmd_wr;
      wire sts_wr;
      wire start;
      wire stop;
      wire irq_edge;

      assign cmd_wr = acc_wr && idm_lane_wr(io_addr, io_be, (ch == 1), `IDM_CMD_LANE);
      assign sts_wr = acc_wr && idm_lane_wr(io_addr, io_be, (ch == 1), `IDM_STS_LANE);
      assign start = cmd_wr && cmd_wbyte[`IDM_CMD_RUN_BIT] && !run_reg;
      assign stop = cmd_wr && !cmd_wbyte[`IDM_CMD_RUN_BIT] && run_reg;
      // Inputs are synchronous, so one stage of history is enough for the edge
      assign irq_edge = drive_irq[ch] && !irq_prev_reg;

      always @* begin
        run_next = run_reg;
        dir_next = dir_reg;
        act_next = act_reg;
        err_next = err_reg;
        irq_next = irq_reg;
        cap_next = cap_reg;
        if (cmd_wr) begin
          // Only bits 3 and 0 are stored; other written bits are dropped
          run_next = cmd_wbyte[`IDM_CMD_RUN_BIT];
          // Direction is taken as written; software keeps it steady while active
          dir_next = cmd_wbyte[`IDM_CMD_DIR_BIT];
        end
        // Set wins over a write-1 clear in the same cycle
        if (sts_wr && sts_wbyte[`IDM_STS_ERR_BIT])
          err_next = 1'b0;
        if (pci_abort[ch] && act_reg)
          err_next = 1'b1;
        if (sts_wr && sts_wbyte[`IDM_STS_IRQ_BIT])
          irq_next = 1'b0;
        if (irq_edge)
          irq_next = 1'b1;
        if (sts_wr) begin
          cap_next[0] = sts_wbyte[`IDM_STS_CAP0_BIT];
          cap_next[1] = sts_wbyte[`IDM_STS_CAP1_BIT];
        end
        // A fresh start outranks a completion or error seen in the same cycle
        if (start)
          act_next = 1'b1;
        else if (stop || last_region_done[ch] || (pci_abort[ch] && act_reg))
          act_next = 1'b0;
      end

      always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          run_reg <= CMD_RST[`IDM_CMD_RUN_BIT];
          dir_reg <= CMD_RST[`IDM_CMD_DIR_BIT];
          act_reg <= STS_RST[`IDM_STS_ACT_BIT];
          err_reg <= STS_RST[`IDM_STS_ERR_BIT];
          irq_reg <= STS_RST[`IDM_STS_IRQ_BIT];
          cap_reg <= {STS_RST[`IDM_STS_CAP1_BIT], STS_RST[`IDM_STS_CAP0_BIT]};
          irq_prev_reg <= 1'b0;
        end else if (clk_en) begin
          run_reg <= run_next;
          dir_reg <= dir_next;
          act_reg <= act_next;
          err_reg <= err_next;
          irq_reg <= irq_next;
          cap_reg <= cap_next;
          irq_prev_reg <= drive_irq[ch];
        end
      end

      assign bus_master_run[ch] = run_reg;
      assign transfer_direction[ch] = dir_reg;
      // Engine may move data only while run and active both hold
      assign xfer_enable[ch] = run_reg && act_reg;
      assign start_pulse[ch] = start;
      // Abort drops any buffered drive data; the engine discards it on this pulse
      assign abort_pulse[ch] = stop && act_reg && !irq_reg;
    end
  endgenerate

  assign pri_cmd = idm_cmd_byte(chan[0].dir_reg, chan[0].run_reg);
  assign sec_cmd = idm_cmd_byte(chan[1].dir_reg, chan[1].run_reg);
  assign pri_ide_dma_status = idm_sts_byte(chan[0].cap_reg, chan[0].irq_reg, chan[0].err_reg,
                                           chan[0].act_reg);
  assign sec_ide_dma_status = idm_sts_byte(chan[1].cap_reg, chan[1].irq_reg, chan[1].err_reg,
                                           chan[1].act_reg);

  // Reads return the whole dword; the master keeps the lanes it enabled
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      io_rdata <= 32'h0000_0000;
      io_ack <= 1'b0;
    end else if (clk_en) begin
      io_ack <= io_hit;
      if (io_hit && io_rd) begin
        if (io_addr[`IDM_DW_SEL_BIT])
          io_rdata <= 32'h0000_0000;
        else if (io_addr[`IDM_CH_SEL_BIT])
          io_rdata <= {8'h00, sec_ide_dma_status, 8'h00, sec_cmd};
        else
          io_rdata <= {8'h00, pri_ide_dma_status, 8'h00, pri_cmd};
      end
    end
  end

endmodule

// File: src/idm_dma_command_defines.vh
// Constants for the two-channel bus-master IDE command and status block.
// Assumes inclusion by bare name from the design file only.
`ifndef IDM_DMA_COMMAND_DEFINES_VH
`define IDM_DMA_COMMAND_DEFINES_VH

// Window size is 16 bytes, so the low 4 address bits pick a register
`define IDM_WIN_BITS 4
`define IDM_BASE_W 28

// Byte offsets inside the window
`define IDM_PRI_CMD_OFS 4'h0
`define IDM_PRI_STS_OFS 4'h2
`define IDM_SEC_CMD_OFS 4'h8
`define IDM_SEC_STS_OFS 4'hA

// Address bit that picks the channel, and bit that picks the dword in a channel
`define IDM_CH_SEL_BIT 3
`define IDM_DW_SEL_BIT 2

// Byte lanes of the command and status bytes inside their dword
`define IDM_CMD_LANE 0
`define IDM_STS_LANE 2

// Command register fields
`define IDM_CMD_RUN_BIT 0
`define IDM_CMD_DIR_BIT 3
`define IDM_CMD_RESET 8'h00

// Status register fields
`define IDM_STS_ACT_BIT 0
`define IDM_STS_ERR_BIT 1
`define IDM_STS_IRQ_BIT 2
`define IDM_STS_CAP0_BIT 5
`define IDM_STS_CAP1_BIT 6
`define IDM_STS_RESET 8'h00

`endif

// File: verification/idm_dma_command_sva.sv
// Checker for the command and status block, primary channel.
// Assumes it is bound to the design top and sees only its ports.
`timescale 1ns/1ps
module idm_dma_command_sva (
  input wire clk_sys,
  input wire arst_n,
  input wire clk_en,
  input wire io_space_en,
  input wire [27:0] dma_io_base,
  input wire io_wr,
  input wire [31:0] io_addr,
  input wire [31:0] io_rdata,
  input wire io_ack,
  input wire io_hit,
  input wire [1:0] last_region_done,
  input wire [1:0] pci_abort,
  input wire [1:0] drive_irq,
  input wire [1:0] bus_master_run,
  input wire [1:0] transfer_direction,
  input wire [1:0] xfer_enable,
  input wire [1:0] start_pulse,
  input wire [1:0] abort_pulse,
  input wire [7:0] pri_ide_dma_status
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  AST_ACK: assert property (io_hit && clk_en |=> io_ack)
    else $error("hit without ack");
  AST_HIT: assert property (io_hit |-> io_space_en && io_addr[31:4] == dma_io_base)
    else $error("hit outside window");
  AST_START: assert property (start_pulse[0] |=>
    bus_master_run[0] && pri_ide_dma_status[0]) else $error("start not taken");
  AST_XFER: assert property (xfer_enable[0] |-> bus_master_run[0])
    else $error("transfer while stopped");
  AST_XFER_START: assert property ($rose(xfer_enable[0]) |-> $past(start_pulse[0]))
    else $error("transfer began without start");
  AST_STOP: assert property ($fell(bus_master_run[0]) |-> !pri_ide_dma_status[0])
    else $error("active after stop");
  AST_ERR: assert property (clk_en && pci_abort[0] && pri_ide_dma_status[0]
    && !start_pulse[0] |=> pri_ide_dma_status[1] && !pri_ide_dma_status[0])
    else $error("abort not flagged");
  AST_IRQ: assert property (clk_en && $past(clk_en) && $rose(drive_irq[0]) |=>
    pri_ide_dma_status[2]) else $error("irq edge missed");
  AST_ABORT: assert property (abort_pulse[0] |-> pri_ide_dma_status[0] &&
    !pri_ide_dma_status[2] ##1 !bus_master_run[0]) else $error("bad abort");
  AST_RSVD: assert property (io_ack |-> io_rdata[7:4] == 0 && io_rdata[2:1] == 0)
    else $error("reserved bits set");
  AST_DIR: assert property ($changed(transfer_direction) |->
    $past(io_hit) && $past(io_wr) && $past(clk_en)) else $error("direction moved alone");
  AST_LAST: assert property (clk_en && last_region_done[0] && !start_pulse[0] |=>
    !pri_ide_dma_status[0]) else $error("active after last region");
  AST_FREEZE: assert property (!clk_en |=> $stable(bus_master_run) &&
    $stable(pri_ide_dma_status) && $stable(io_ack) && $stable(io_rdata))
    else $error("state moved while clock enable low");
endmodule
bind idm_dma_command idm_dma_command_sva u_sva (.clk_sys(clk_sys), .arst_n(arst_n),
  .clk_en(clk_en), .io_space_en(io_space_en), .dma_io_base(dma_io_base), .io_wr(io_wr),
  .io_addr(io_addr), .io_rdata(io_rdata), .io_ack(io_ack), .io_hit(io_hit),
  .last_region_done(last_region_done), .pci_abort(pci_abort), .drive_irq(drive_irq),
  .bus_master_run(bus_master_run), .transfer_direction(transfer_direction),
  .xfer_enable(xfer_enable), .start_pulse(start_pulse), .abort_pulse(abort_pulse),
  .pri_ide_dma_status(pri_ide_dma_status));

// File: verification/idm_drive_model.sv
// Drive and PCI side events for both channels, driven at the falling edge.
// Assumes the bench calls its tasks; completion and abort only while the channel transfers.
`timescale 1ns/1ps
module idm_drive_model (
  input wire clk_sys,
  input wire [1:0] xfer_enable,
  output logic [1:0] drive_irq = 0,
  output logic [1:0] last_region_done = 0,
  output logic [1:0] pci_abort = 0
);
  task irq(input int c, input logic v);
    @(negedge clk_sys) drive_irq[c] = v;
  endtask
  // Completion or abort only while moving data
  task ev(input int c, input logic a);
    @(negedge clk_sys);
    if (a) pci_abort[c] = xfer_enable[c];
    else last_region_done[c] = xfer_enable[c];
    @(negedge clk_sys);
    pci_abort = 0;
    last_region_done = 0;
  endtask
endmodule

// File: verification/tb_top.sv
// Self-checking bench for the command block against a register model.
// Assumes the design, its defines header and the drive model are compiled.
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 0, arst_n = 0, io_space_en = 1, io_wr = 0, io_rd = 0, io_ack, clk_en = 1;
  logic [27:0] base = 0, hi = 0;
  logic [31:0] io_addr = 0, io_wdata = 0, io_rdata, s = 32'h0e2a_010a, d;
  logic [3:0] io_be = 0;
  logic [1:0] irq, done, abt, xen, run, dir, sp, ap, sp_q, ap_q;
  logic hit, hit_q;
  logic [7:0] cmd [2], st [2], ps, ss;
  int n_errors = 0, samples_checked = 0;
  initial forever #12.5 clk_sys = ~clk_sys;
  idm_dma_command DUT (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en),
    .io_space_en(io_space_en), .dma_io_base(base), .io_wr(io_wr), .io_rd(io_rd),
    .io_addr(io_addr), .io_be(io_be), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .io_ack(io_ack), .io_hit(hit), .last_region_done(done), .pci_abort(abt), .drive_irq(irq),
    .bus_master_run(run), .transfer_direction(dir), .xfer_enable(xen), .start_pulse(sp),
    .abort_pulse(ap), .pri_ide_dma_status(ps), .sec_ide_dma_status(ss));
  idm_drive_model drv (.clk_sys(clk_sys), .xfer_enable(xen), .drive_irq(irq),
    .last_region_done(done), .pci_abort(abt));
  function logic [31:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task chk(input logic [31:0] a, input logic [31:0] e);
    samples_checked++;
    if (a !== e) begin
      n_errors++;
      $display("wrong value t=%0t got %h exp %h", $time, a, e);
    end
  endtask
  task complete_run;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task acc(input logic w, input logic [3:0] o, input logic [3:0] be,
    input logic [31:0] wd, input logic [31:0] e, input logic a);
    @(negedge clk_sys);
    io_wr = w;
    io_rd = !w;
    io_addr = {hi, o};
    io_be = be;
    io_wdata = wd;
    // Combinational outputs are taken once settled, before the edge that takes the access
    #1;
    hit_q = hit;
    sp_q = sp;
    ap_q = ap;
    @(negedge clk_sys);
    io_wr = 0;
    io_rd = 0;
    chk(hit_q, io_space_en && hi == base);
    chk(io_ack, a);
    if (a && !w) chk(io_rdata, e);
  endtask
  task rdc(input int c);
    acc(0, 4'(c * 8), 4'hF, 0, {8'h0, st[c], 8'h0, cmd[c]}, 1);
    chk(c ? ss : ps, st[c]);
    chk({run[c], dir[c], xen[c]}, {cmd[c][0], cmd[c][3], cmd[c][0] && st[c][0]});
  endtask
  task wcmd(input int c, input logic [7:0] v);
    acc(1, 4'(c * 8), 4'h1, {24'h0, v}, 0, 1);
    chk(sp_q[c], v[0] && !cmd[c][0]);
    chk(ap_q[c], !v[0] && cmd[c][0] && st[c][0] && !st[c][2]);
    if (v[0] && !cmd[c][0]) st[c][0] = 1;
    if (!v[0]) st[c][0] = 0;
    cmd[c] = v & 8'h09;
    rdc(c);
  endtask
  task wst(input int c, input logic [7:0] v);
    acc(1, 4'(c * 8), 4'h4, {8'h0, v, 16'h0}, 0, 1);
    st[c][2:1] = st[c][2:1] & ~v[2:1];
    st[c][6:5] = v[6:5];
    rdc(c);
  endtask
  initial begin
    d = xs();
    base = d[27:0];
    hi = d[27:0];
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys) arst_n = 1;
    for (int c = 0; c < 2; c++) begin
      cmd[c] = 0;
      st[c] = 0;
      rdc(c);
    end
    acc(0, 4'h4, 4'hF, 0, 0, 1);
    io_space_en = 0;
    acc(0, 4'h0, 4'hF, 0, 0, 0);
    io_space_en = 1;
    hi = ~base;
    acc(0, 4'h0, 4'hF, 0, 0, 0);
    hi = base;
    // A low clock enable must swallow a start write and the acknowledge
    @(negedge clk_sys) clk_en = 0;
    acc(1, 4'h0, 4'h1, 32'h0000_0009, 0, 0);
    clk_en = 1;
    rdc(0);
    repeat (24) begin
      d = xs();
      if (cmd[d[8]][0]) d[3] = cmd[d[8]][3];
      wcmd(d[8], d[7:0]);
    end
    for (int c = 0; c < 2; c++) begin
      wcmd(c, 8'h00);
      wcmd(c, 8'h09);
      drv.irq(c, 1);
      st[c][2] = 1;
      rdc(c);
      wst(c, 8'h04);
      drv.irq(c, 0);
      drv.ev(c, 0);
      st[c][0] = 0;
      rdc(c);
      wcmd(c, 8'h08);
      wcmd(c, 8'h09);
      drv.ev(c, 1);
      st[c][1] = 1;
      st[c][0] = 0;
      rdc(c);
      wst(c, 8'h62);
      acc(1, 4'(c * 8), 4'h5, 32'h0000_0000, 0, 1);
      cmd[c] = 0;
      st[c][6:5] = 0;
      rdc(c);
    end
    complete_run;
  end
  initial begin
    #100000;
    n_errors++;
    complete_run;
  end
endmodule
